// *** rtl/lfd_pkg.sv ***
package lfd_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 5;
	// fixed fault timing, not reachable by software
	localparam int DEGLITCH_NS = 10000;
	localparam int MASK_NS = 120000;
	localparam int HICCUP_NS = 1000000;
	// least times round up, the hiccup period rounds down
	localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_CYC = (MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HICCUP_CYC = HICCUP_NS / CLK_PERIOD_NS;
	localparam int REG_SW_CYC = 256;
	localparam int TMR_W = 18;

	// wishbone register map, byte addresses
	localparam logic [3:0] CTRL_ADR = 4'h0;
	localparam logic [3:0] STATUS_ADR = 4'h4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_EN_BIT = 0;
	localparam int ST_FLAG_BIT = 0;
	localparam int ST_OPEN_BIT = 1;
	localparam int ST_SHORT_BIT = 2;
	localparam int ST_HICCUP_BIT = 3;
	localparam int ST_MASK_BIT = 4;
	localparam int ST_REG_BIT = 5;
	localparam int ST_PWM_BIT = 6;

	// synchronised pin positions
	localparam int PIN_PWM = 0;
	localparam int PIN_VIN_OK = 1;
	localparam int PIN_ANALOG_DIM_LEVEL_OK = 2;
	localparam int PIN_OPEN = 3;
	localparam int PIN_VOUT_LOW = 4;
	localparam int PIN_DUTY_MIN = 5;
	localparam int PIN_SW_TICK = 6;
	localparam int PIN_N = 7;

	typedef enum logic [1:0] {
		LFD_RUN = 2'b00,
		LFD_HICCUP = 2'b01,
		LFD_RETRY = 2'b10
	} lfd_state_t;
endpackage : lfd_pkg

// *** rtl/lfd_sync.sv ***
module lfd_sync #(
	parameter int N = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [N-1:0] async_i,
	output logic [N-1:0] sync_o
);
	logic [N-1:0] meta_q;
	logic [N-1:0] sync_q;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_bit
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					meta_q[g] <= 1'b0;
					sync_q[g] <= 1'b0;
				end
				else
				begin
					meta_q[g] <= async_i[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_q;
endmodule : lfd_sync

// *** rtl/lfd_timer.sv ***
module lfd_timer #(
	parameter int W = 18
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [W-1:0] limit_i,
	output logic done_o
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic at_limit;

	// saturating count, so done stays up until the next clear
	assign at_limit = (cnt_q == limit_i);
	assign cnt_d = clr_i ? '0 : ((en_i && !at_limit) ? cnt_q + 1'b1 : cnt_q);
	assign done_o = at_limit && !clr_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule : lfd_timer

// *** rtl/lfd_top.sv ***
module lfd_top #(
	parameter int MASK_CYCLES = lfd_pkg::MASK_CYC,
	parameter int HICCUP_CYCLES = lfd_pkg::HICCUP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pwm_i,
	input wire logic input_voltage_mask_threshold_i,
	input wire logic analog_dim_level_i,
	input wire logic open_cond_i,
	input wire logic vout_low_i,
	input wire logic duty_below_min_i,
	input wire logic sw_tick_i,
	output logic fault_flag_low_o,
	output logic switching_o,
	output logic min_on_time_o,
	output logic extend_off_time_o,
	output logic regulated_o,
	output logic hiccup_o
);
	import lfd_pkg::*;

	localparam logic [TMR_W-1:0] DG_LIM = TMR_W'(DEGLITCH_CYC);
	localparam logic [TMR_W-1:0] MASK_LIM = TMR_W'(MASK_CYCLES);
	localparam logic [TMR_W-1:0] HIC_LIM = TMR_W'(HICCUP_CYCLES);
	localparam logic [TMR_W-1:0] REG_LIM = TMR_W'(REG_SW_CYC);

	logic [PIN_N-1:0] pins_s;
	logic pwm_s;
	logic vin_ok_s;
	logic analog_dim_level_ok_s;
	logic open_s;
	logic vout_low_s;
	logic duty_min_s;
	logic sw_s;
	logic pwm_d1_q;
	logic sw_d1_q;
	logic pwm_rise;
	logic sw_tick;

	// comparator inputs pass two flops first
	lfd_sync #(
		.N(PIN_N)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({sw_tick_i, duty_below_min_i, vout_low_i, open_cond_i,
			analog_dim_level_i, input_voltage_mask_threshold_i, pwm_i}),
		.sync_o(pins_s)
	);

	assign pwm_s = pins_s[PIN_PWM];
	assign vin_ok_s = pins_s[PIN_VIN_OK];
	assign analog_dim_level_ok_s = pins_s[PIN_ANALOG_DIM_LEVEL_OK];
	assign open_s = pins_s[PIN_OPEN];
	assign vout_low_s = pins_s[PIN_VOUT_LOW];
	assign duty_min_s = pins_s[PIN_DUTY_MIN];
	assign sw_s = pins_s[PIN_SW_TICK];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwm_d1_q <= 1'b0;
			sw_d1_q <= 1'b0;
		end
		else
		begin
			pwm_d1_q <= pwm_s;
			sw_d1_q <= sw_s;
		end
	end

	assign pwm_rise = pwm_s && !pwm_d1_q;
	assign sw_tick = sw_s && !sw_d1_q;

	// control register
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic enable;
	logic wb_req;
	logic wb_wr;
	logic ctrl_hit;
	logic status_hit;
	logic [31:0] status_w;
	logic [31:0] rd_data;
	logic [31:0] sel_mask;

	assign enable = ctrl_q[CTRL_EN_BIT];
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign ctrl_hit = (wb_adr_i == CTRL_ADR);
	assign status_hit = (wb_adr_i == STATUS_ADR);
	assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign ctrl_d = (wb_wr && ctrl_hit) ? ((ctrl_q & ~sel_mask) | (wb_dat_i & sel_mask)) : ctrl_q;

	// fault qualification
	logic mask_done;
	logic mask_act;
	logic detect;
	logic open_unmasked;
	logic open_raw;
	logic short_raw;
	logic open_conf;
	logic short_conf;
	logic open_flag_q;
	logic open_flag_d;
	logic short_flag_q;
	logic short_flag_d;
	logic flag_low_q;

	lfd_timer #(
		.W(TMR_W)
	) u_mask (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(pwm_rise),
		.en_i(1'b1),
		.limit_i(MASK_LIM),
		.done_o(mask_done)
	);

	// fixed intervals come from constants only
	assign mask_act = pwm_s && !mask_done;
	assign detect = pwm_s && !pwm_rise && mask_done && enable;
	assign open_unmasked = vin_ok_s && analog_dim_level_ok_s;
	assign open_raw = detect && open_unmasked && open_s;
	assign short_raw = detect && analog_dim_level_ok_s && vout_low_s;

	// fault must stand through the whole deglitch interval
	lfd_timer #(
		.W(TMR_W)
	) u_dg_open (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!open_raw),
		.en_i(open_raw),
		.limit_i(DG_LIM),
		.done_o(open_conf)
	);

	lfd_timer #(
		.W(TMR_W)
	) u_dg_short (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!short_raw),
		.en_i(short_raw),
		.limit_i(DG_LIM),
		.done_o(short_conf)
	);

	// hiccup sequencer, open fault only
	lfd_state_t state_q;
	lfd_state_t state_d;
	logic hic_done;
	logic hic_end_clear;
	logic in_hiccup;

	assign in_hiccup = (state_q == LFD_HICCUP);

	lfd_timer #(
		.W(TMR_W)
	) u_hiccup (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!in_hiccup),
		.en_i(1'b1),
		.limit_i(HIC_LIM),
		.done_o(hic_done)
	);

	// release only when the period ends with PWM high
	assign hic_end_clear = in_hiccup && hic_done && !open_s && pwm_s;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			LFD_RUN:
				if (open_conf)
					state_d = LFD_HICCUP;
			LFD_HICCUP:
				if (hic_done)
					state_d = LFD_RETRY;
			LFD_RETRY:
				state_d = LFD_RUN;
			default:
				state_d = LFD_RUN;
		endcase
	end

	// open flag: set wins over any clear in the same cycle
	always_comb
	begin
		open_flag_d = open_flag_q;
		if (open_conf)
			open_flag_d = 1'b1;
		else if (hic_end_clear)
			open_flag_d = 1'b0;
		else if (detect && !in_hiccup && !open_s)
			open_flag_d = 1'b0;
	end

	// short flag never touches the hiccup sequencer
	always_comb
	begin
		short_flag_d = short_flag_q;
		if (short_conf)
			short_flag_d = 1'b1;
		else if (detect && !vout_low_s)
			short_flag_d = 1'b0;
	end

	// regulation ramp timer in switching cycles
	logic reg_done;
	logic reg_start;

	assign reg_start = pwm_rise || (state_q == LFD_RETRY);

	lfd_timer #(
		.W(TMR_W)
	) u_reg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(reg_start),
		.en_i(sw_tick),
		.limit_i(REG_LIM),
		.done_o(reg_done)
	);

	logic switching;

	assign switching = enable && pwm_s && !in_hiccup;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= LFD_RUN;
			open_flag_q <= 1'b0;
			short_flag_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			open_flag_q <= open_flag_d;
			short_flag_q <= short_flag_d;
		end
	end

	// flag output only moves while PWM is high, so the fall latches it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_low_q <= 1'b1;
		else if (pwm_s)
			flag_low_q <= !(open_flag_d || short_flag_d);
	end

	// modulator hints; short keeps switching at minimum on-time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			switching_o <= 1'b0;
			min_on_time_o <= 1'b0;
			extend_off_time_o <= 1'b0;
			regulated_o <= 1'b0;
			hiccup_o <= 1'b0;
		end
		else
		begin
			switching_o <= switching;
			min_on_time_o <= switching && vout_low_s;
			extend_off_time_o <= switching && duty_min_s;
			regulated_o <= switching && reg_done;
			hiccup_o <= in_hiccup;
		end
	end

	assign fault_flag_low_o = flag_low_q;

	// status word, reserved bits read zero
	assign status_w = {25'h000_0000, pwm_s, reg_done, mask_act, in_hiccup,
		short_flag_q, open_flag_q, !flag_low_q};
	assign rd_data = ctrl_hit ? ctrl_q : (status_hit ? status_w : 32'h0000_0000);

	// every access is acked one cycle later; unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence pwm_fell_s;
		pwm_d1_q && !pwm_s;
	endsequence

	sequence pwm_low_s;
		!pwm_s [*3];
	endsequence

	flag_hold_low_a: assert property (pwm_fell_s ##0 pwm_low_s |-> $stable(fault_flag_low_o))
		else $error("fault flag moved while pwm low");
	open_ignore_a: assert property (!(vin_ok_s && analog_dim_level_ok_s) |=> !$rose(open_flag_q))
		else $error("open evaluated while masked");
	mask_window_a: assert property (pwm_rise |=> !detect [*8])
		else $error("detection inside mask interval");
	mask_no_det_a: assert property (mask_act |-> !open_raw && !short_raw)
		else $error("fault seen during mask");
	hiccup_entry_a: assert property ($rose(in_hiccup) |-> $past(open_conf))
		else $error("hiccup entered without open fault");
	hiccup_flag_a: assert property (in_hiccup |-> open_flag_q && !fault_flag_low_o)
		else $error("flag not held in hiccup");
	release_a: assert property ($fell(open_flag_q) |-> $past(pwm_s) && !$past(open_s))
		else $error("open flag released badly");
	short_set_a: assert property ($rose(short_flag_q) |-> $past(analog_dim_level_ok_s && short_conf))
		else $error("short flag without cause");
	open_dg_a: assert property ($rose(open_flag_q) |-> $past(open_raw) && $past(open_conf))
		else $error("open flag before deglitch");
	short_no_hic_a: assert property (short_conf && !open_conf && !in_hiccup |=> !in_hiccup)
		else $error("short caused hiccup");
	min_ton_a: assert property (switching && vout_low_s |=> min_on_time_o)
		else $error("minimum on-time not applied");
	ramp_a: assert property (reg_start |=> !reg_done [*2])
		else $error("regulation timer not restarted");
endmodule : lfd_top

// *** tb/lfd_host.sv ***
module lfd_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [15:0] len_i,
	input wire logic flag_i,
	output logic pwm_o,
	output logic done_o,
	output logic seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_q;
	// the bench picks the high time; normal pulses outlast mask plus deglitch
	always_ff @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (rst_i)
		begin
			pwm_o <= 1'b0;
			cnt_q <= 16'h0000;
			seen_o <= 1'b1;
		end
		else if (pwm_o)
		begin
			cnt_q <= cnt_q + 16'h0001;
			if (cnt_q == len_i)
			begin
				pwm_o <= 1'b0;
				seen_o <= flag_i;
				done_o <= 1'b1;
			end
		end
		else if (go_i && !done_o)
		begin
			pwm_o <= 1'b1;
			cnt_q <= 16'h0001;
		end
	end
endmodule : lfd_host

// *** tb/test_lfd_top.sv ***
module test_lfd_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, we, cyc, stb, ack, go, done, seen, pwm;
	logic vin, analog_dim_level, opn, sht, dmin, swt, ten, flag, sw, mot, ext, regd, hic;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat, q;
	logic [15:0] len;
	logic [2:0] tc;
	int err_total, n_compared, cyc_cnt;
	// {input ok, dim ok, open, short, flag at pulse end}
	logic [4:0] rows [9] = '{5'b11001, 5'b01101, 5'b10101, 5'b11100, 5'b01100,
		5'b01001, 5'b10011, 5'b11010, 5'b11001};
	lfd_top #(.MASK_CYCLES(50), .HICCUP_CYCLES(200)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .pwm_i(pwm),
		.input_voltage_mask_threshold_i(vin), .analog_dim_level_i(analog_dim_level),
		.open_cond_i(opn), .vout_low_i(sht), .duty_below_min_i(dmin), .sw_tick_i(swt),
		.fault_flag_low_o(flag), .switching_o(sw), .min_on_time_o(mot),
		.extend_off_time_o(ext), .regulated_o(regd), .hiccup_o(hic));
	lfd_host HOST (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len), .flag_i(flag),
		.pwm_o(pwm), .done_o(done), .seen_o(seen));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// switching ticks every 8 clocks, only while enabled
	always @(posedge clk_i)
	begin
		tc <= tc + 3'h1;
		swt <= ten & tc[2];
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic summarize();
		$display("compared=%0d errors=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic pulse(input int n);
		// one edge between pulses so go is never written twice in a step
		@(posedge clk_i);
		len <= n[15:0];
		go <= 1'b1;
		do @(posedge clk_i); while (done !== 1'b1);
		go <= 1'b0;
	endtask : pulse
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle
	initial
	begin
		{rst_i, we, cyc, stb, go, vin, analog_dim_level, opn, sht, dmin, ten} = 11'h401;
		{adr, sel, wdat, len, tc, err_total, n_compared, cyc_cnt} = '0;
		rst_i = 1'b1;
		ten = 1'b0;
		idle(8);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({flag, sw, hic, regd}, 4'h8);
		wb(1'b0, 4'h0, 4'hf, 32'h0);
		chk(q, 32'h0000_0001);
		wb(1'b1, 4'h0, 4'h0, 32'h0);
		wb(1'b0, 4'h0, 4'hf, 32'h0);
		chk(q, 32'h0000_0001);
		wb(1'b1, 4'h0, 4'h1, 32'h0);
		wb(1'b0, 4'h0, 4'hf, 32'h0);
		chk(q, 32'h0);
		{vin, analog_dim_level, opn} <= 3'b111;
		pulse(2400);
		chk(seen, 1'b1);
		wb(1'b1, 4'h0, 4'h1, 32'h0000_0001);
		wb(1'b0, 4'h8, 4'hf, 32'h0);
		chk(q, 32'h0);
		foreach (rows[i])
		begin
			{vin, analog_dim_level, opn, sht} <= rows[i][4:1];
			pulse(2400);
			chk(seen, rows[i][0]);
			opn <= ~rows[i][2];
			idle(300);
			chk(flag, rows[i][0]);
		end
		{opn, sht} <= 2'b01;
		fork
			pulse(2400);
			begin
				idle(2300);
				chk({sw, mot, hic}, 3'b110);
			end
		join
		sht <= 1'b0;
		pulse(2400);
		chk(seen, 1'b1);
		{ten, dmin} <= 2'b11;
		fork
			pulse(2400);
			begin
				idle(1900);
				chk(regd, 1'b0);
				idle(300);
				chk({regd, ext}, 2'b11);
			end
		join
		{ten, dmin} <= 2'b00;
		// too short on purpose: fault lies inside mask plus deglitch
		opn <= 1'b1;
		pulse(2020);
		chk(seen, 1'b1);
		opn <= 1'b0;
		fork
			pulse(2400);
			begin
				idle(200);
				opn <= 1'b1;
				idle(1000);
				opn <= 1'b0;
			end
		join
		chk(seen, 1'b1);
		// open cleared mid-hiccup: flag held to period end, then released while pwm high
		opn <= 1'b1;
		fork
			pulse(2400);
			begin
				idle(2100);
				wb(1'b0, 4'h4, 4'hf, 32'h0);
				chk(q, 32'h0000_004B);
				opn <= 1'b0;
				idle(45);
				chk({hic, sw, flag}, 3'b100);
				idle(100);
				chk({hic, sw, flag}, 3'b100);
				idle(50);
				chk({hic, sw, flag}, 3'b011);
			end
		join
		chk(seen, 1'b1);
		summarize();
	end
endmodule : test_lfd_top
